// *** rtl/nbr_bus_register.sv ***
// Purpose: Nine-bit edge-triggered bus register with released outputs.
// Assumes: All inputs are synchronous to clk_sys_i at 125 MHz.
// Notes:   Words arrive through a 16-word buffer; each enabled edge
//          with a word waiting moves the head word into storage.
`timescale 1ns/1ns
`include "nbr_params.svh"

module nbr_bus_register #(
  parameter bit INVERT = `NBR_INVERT_DEFAULT
) (
  // Clock and reset.
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // Data stream from the driving logic.
  input wire logic [`NBR_WIDTH-1:0] data_i,
  input wire logic data_valid_i,
  output logic data_ready_o,
  // Controls, all active low.
  input wire logic capture_gate_n_i,
  input wire logic async_zero_n_i,
  input wire logic output_drive_enable_n_i,
  // Bus pins: level and output enable of each three-state output.
  output logic [`NBR_WIDTH-1:0] q_o,
  output logic [`NBR_WIDTH-1:0] q_oe_o,
  // Status.
  output logic [$clog2(`NBR_DEPTH):0] fifo_level_o,
  output logic word_pending_o
);

  // --------------------------------------------------------------------
  // Signals
  // --------------------------------------------------------------------

  nbr_pkg::nbr_word_t head_word;
  nbr_pkg::nbr_word_t stored_word;
  nbr_pkg::nbr_drive_state_e drive_state_q;
  nbr_pkg::nbr_drive_state_e drive_state_d;
  logic head_valid;
  logic load;
  logic drive_on;

  // --------------------------------------------------------------------
  // Word buffer
  // --------------------------------------------------------------------

  // The buffer stalls the source whenever the gate is closed long enough
  // to fill it, so words are never dropped while capture is frozen.
  nbr_fifo #(
    .WIDTH(`NBR_WIDTH),
    .DEPTH(`NBR_DEPTH)
  ) u_fifo (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .in_data_i(data_i),
    .in_valid_i(data_valid_i),
    .in_ready_o(data_ready_o),
    .out_data_o(head_word),
    .out_valid_o(head_valid),
    .out_ready_i(load),
    .level_o(fifo_level_o)
  );

  assign word_pending_o = head_valid;

  // --------------------------------------------------------------------
  // Capture decision
  // --------------------------------------------------------------------

  // A word moves into storage only on an open gate; a word that meets a
  // clear stays in the buffer, since the clear would destroy it anyway.
  // The drive control takes no part here.
  assign load = !capture_gate_n_i && async_zero_n_i && head_valid;

  // --------------------------------------------------------------------
  // Storage elements
  // --------------------------------------------------------------------

  // One cell per bit; each cell applies clear, load and the variant.
  for (genvar gi = 0; gi < `NBR_WIDTH; gi++)
  begin : g_bit
    nbr_store_bit #(
      .INVERT(INVERT)
    ) u_bit (
      .clk_sys_i(clk_sys_i),
      .rst_n_i(rst_n_i),
      .clear_n_i(async_zero_n_i),
      .load_i(load),
      .d_i(head_word[gi]),
      .q_o(stored_word[gi])
    );
  end

  // --------------------------------------------------------------------
  // Output driver state
  // --------------------------------------------------------------------

  // The pins stay released from reset until the first low on the drive
  // control, so a newly reset part never fights a shared bus.
  always_comb
  begin
    drive_state_d = drive_state_q;
    case (drive_state_q)
      nbr_pkg::NBR_ST_POWERUP:
      begin
        if (!output_drive_enable_n_i)
        begin
          drive_state_d = nbr_pkg::NBR_ST_ARMED;
        end
      end
      nbr_pkg::NBR_ST_ARMED:
      begin
        drive_state_d = nbr_pkg::NBR_ST_ARMED;
      end
      default:
      begin
        drive_state_d = nbr_pkg::NBR_ST_POWERUP;
      end
    endcase
  end

  // Driver state register.
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      drive_state_q <= nbr_pkg::NBR_ST_POWERUP;
    end
    else
    begin
      drive_state_q <= drive_state_d;
    end
  end

  // --------------------------------------------------------------------
  // Pins
  // --------------------------------------------------------------------

  // The driver follows the control in the same cycle once armed; the arm
  // step itself also enables, so the first low drives without delay.
  assign drive_on = !output_drive_enable_n_i &&
                    (drive_state_q == nbr_pkg::NBR_ST_ARMED ||
                     drive_state_d == nbr_pkg::NBR_ST_ARMED);
  assign q_oe_o = drive_on ? `NBR_OE_ON : `NBR_OE_OFF;

  // The clear masks the pins in its own cycle, before the cells settle,
  // which is as close to immediate as a synchronous design allows.
  assign q_o = async_zero_n_i ? stored_word : `NBR_STORE_RST;

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------

  nbr_pkg::nbr_word_t expect_word;

  // Word that a capture should store, after the build variant.
  assign expect_word = INVERT ? ~head_word : head_word;

  // An enabled edge with a word waiting, and the word after it.
  sequence s_capture;
    !capture_gate_n_i && async_zero_n_i && head_valid;
  endsequence

  sequence s_stored_as_expected;
    stored_word == $past(expect_word);
  endsequence

  property p_capture;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    s_capture |=> s_stored_as_expected;
  endproperty
  a_capture: assert property (p_capture)
    else $error("Enabled edge did not store the head word.");

  property p_hold;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    capture_gate_n_i && async_zero_n_i |=> $stable(stored_word);
  endproperty
  a_hold: assert property (p_hold)
    else $error("Stored word changed while the gate was closed.");

  property p_clear;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    !async_zero_n_i |-> (q_o == `NBR_STORE_RST) ##1
                        (stored_word == `NBR_STORE_RST);
  endproperty
  a_clear: assert property (p_clear)
    else $error("Clear did not zero the pins and the storage.");

  property p_release;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    output_drive_enable_n_i |-> (q_oe_o == `NBR_OE_OFF);
  endproperty
  a_release: assert property (p_release)
    else $error("Pins driven while the drive control was high.");

  property p_drive;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    !output_drive_enable_n_i |-> (q_oe_o == `NBR_OE_ON) &&
      (q_o == (async_zero_n_i ? stored_word : `NBR_STORE_RST));
  endproperty
  a_drive: assert property (p_drive)
    else $error("Pins not driven with the stored word.");

  property p_capture_released;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    output_drive_enable_n_i ##0 s_capture |=> s_stored_as_expected;
  endproperty
  a_capture_released: assert property (p_capture_released)
    else $error("Capture failed while the pins were released.");

  // A released stretch of three cycles, then the pins driven again.
  sequence s_released_then_driven;
    output_drive_enable_n_i [*3] ##1 !output_drive_enable_n_i;
  endsequence

  property p_reappear;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    s_released_then_driven |-> (q_oe_o == `NBR_OE_ON) &&
      (!async_zero_n_i || q_o == stored_word);
  endproperty
  a_reappear: assert property (p_reappear)
    else $error("Word did not reappear when the pins were driven again.");

  property p_powerup;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    $rose(rst_n_i) ##0 output_drive_enable_n_i |->
      (q_oe_o == `NBR_OE_OFF) && (drive_state_q == nbr_pkg::NBR_ST_POWERUP);
  endproperty
  a_powerup: assert property (p_powerup)
    else $error("Pins left the released state before the first enable.");

  property p_stall;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    capture_gate_n_i && !data_ready_o |=> !data_ready_o;
  endproperty
  a_stall: assert property (p_stall)
    else $error("Full buffer drained while the gate was closed.");

  // --------------------------------------------------------------------
  // Buffer and pin checks
  // --------------------------------------------------------------------

  // A taken word with no capture grows the buffer by exactly one.
  property p_push_count;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    data_valid_i && data_ready_o && !load |=>
      fifo_level_o == $past(fifo_level_o) + 1'b1;
  endproperty
  a_push_count: assert property (p_push_count)
    else $error("Buffer level did not grow on a taken word.");

  // A capture with no word taken shrinks the buffer by exactly one.
  property p_pop_count;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    load && !(data_valid_i && data_ready_o) |=>
      fifo_level_o == $past(fifo_level_o) - 1'b1;
  endproperty
  a_pop_count: assert property (p_pop_count)
    else $error("Buffer level did not shrink on a capture.");

  // A full buffer refuses words, so a closed gate never loses one.
  property p_full_refuses;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    int'(fifo_level_o) == `NBR_DEPTH |-> !data_ready_o;
  endproperty
  a_full_refuses: assert property (p_full_refuses)
    else $error("Full buffer still offered to take a word.");

  // Room in the buffer must never stall the source.
  property p_room_accepts;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    int'(fifo_level_o) < `NBR_DEPTH |-> data_ready_o;
  endproperty
  a_room_accepts: assert property (p_room_accepts)
    else $error("Buffer with room refused a word.");

  // A clear leaves waiting words in the buffer for later capture.
  property p_clear_keeps;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    !async_zero_n_i && head_valid |=> word_pending_o;
  endproperty
  a_clear_keeps: assert property (p_clear_keeps)
    else $error("Clear dropped a waiting word.");

  // Driven and not cleared: the pins can show the stored word.
  sequence s_shown;
    !output_drive_enable_n_i && async_zero_n_i;
  endsequence

  // Once a word is stored, driven pins carry it after the variant.
  property p_pins_show_capture;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    s_capture ##1 s_shown |-> q_o == $past(expect_word);
  endproperty
  a_pins_show_capture: assert property (p_pins_show_capture)
    else $error("Driven pins did not carry the captured word.");

  // All nine drivers switch together; a split enable would tear the bus.
  property p_oe_whole;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    q_oe_o == `NBR_OE_ON || q_oe_o == `NBR_OE_OFF;
  endproperty
  a_oe_whole: assert property (p_oe_whole)
    else $error("Pin enables were not all equal.");

endmodule : nbr_bus_register

// *** rtl/nbr_params.svh ***
// Purpose: Constants of the nine-bit bus register.
// Assumes: Included by the package, by nbr_bus_register and by the sim files.
// Notes:   Definitions only.
`ifndef NBR_PARAMS_SVH
`define NBR_PARAMS_SVH

// Width of the stored word and of the output pins.
`define NBR_WIDTH 9
// Depth of the word buffer in front of the storage; a power of two.
`define NBR_DEPTH 16
// Value of the storage elements after reset and while cleared.
`define NBR_STORE_RST 9'h000
// Default build variant: 1'b0 stores data as is, 1'b1 stores its complement.
`define NBR_INVERT_DEFAULT 1'b0
// Output enable value while the pins are released.
`define NBR_OE_OFF 9'h000
// Output enable value while the pins are driven.
`define NBR_OE_ON 9'h1ff

`endif

// *** rtl/nbr_pkg.sv ***
// Purpose: Types shared by the nine-bit bus register modules.
// Assumes: nbr_params.svh gives the word width.
// Notes:   Holds types only; numbers live in the header.
`include "nbr_params.svh"

package nbr_pkg;

  // One stored or transported word.
  typedef logic [`NBR_WIDTH-1:0] nbr_word_t;

  // Output driver state: released since power-up, or armed by the control.
  typedef enum logic {
    NBR_ST_POWERUP,
    NBR_ST_ARMED
  } nbr_drive_state_e;

endpackage : nbr_pkg

// *** rtl/nbr_store_bit.sv ***
// Purpose: One storage element of the bus register.
// Assumes: Clear and load are synchronous to clk_sys_i.
// Notes:   INVERT selects the complementing build variant.
`timescale 1ns/1ns

module nbr_store_bit #(
  parameter bit INVERT = 1'b0
) (
  // Clock and reset.
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // Control.
  input wire logic clear_n_i,
  input wire logic load_i,
  // Data.
  input wire logic d_i,
  output logic q_o
);

  logic q_q;

  // Clear beats load; load takes the bit or its complement.
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i || !clear_n_i)
    begin
      q_q <= 1'b0;
    end
    else if (load_i)
    begin
      q_q <= INVERT ? ~d_i : d_i;
    end
  end

  assign q_o = q_q;

endmodule : nbr_store_bit

// *** rtl/nbr_fifo.sv ***
// Purpose: Word buffer with valid and ready on both sides.
// Assumes: DEPTH is a power of two so the pointers wrap by themselves.
// Notes:   Storage is flip-flops; the head word is read by index.
`timescale 1ns/1ns

module nbr_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  // Clock and reset.
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // Filling side.
  input wire logic [WIDTH-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  // Draining side.
  output logic [WIDTH-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i,
  // Status.
  output logic [$clog2(DEPTH):0] level_o
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  // Handshakes; full and empty come straight from the count.
  // Only a full count refuses; an empty buffer must take the first word.
  assign in_ready_o = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid_o = (cnt_q != '0);
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  assign out_data_o = mem_q[rd_q];
  assign level_o = cnt_q;

  // Storage write.
  always_ff @(posedge clk_sys_i)
  begin
    if (push)
    begin
      mem_q[wr_q] <= in_data_i;
    end
  end

  // Pointers.
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      wr_q <= '0;
      rd_q <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop)
      begin
        rd_q <= rd_q + 1'b1;
      end
    end
  end

  // Fill count.
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      cnt_q <= '0;
    end
    else if (push && !pop)
    begin
      cnt_q <= cnt_q + 1'b1;
    end
    else if (pop && !push)
    begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

endmodule : nbr_fifo

// *** sim/nbr_bus_partner.sv ***
// Purpose: Model of the shared bus on the far side of the register.
// Assumes: One other talker shares the nine lines with the register.
// Notes:   The bus has no pull-up, so a line nobody drives drifts.
`timescale 1ns/1ns
`include "nbr_params.svh"

module nbr_bus_partner (
  // Clock.
  input wire logic clk_sys_i,
  // Register pins.
  input wire nbr_pkg::nbr_word_t q_i,
  input wire nbr_pkg::nbr_word_t oe_i,
  // Other talker on the bus.
  input wire logic talk_i,
  input wire nbr_pkg::nbr_word_t talk_word_i,
  // Resolved bus.
  output nbr_pkg::nbr_word_t bus_o,
  output logic clash_o
);
  nbr_pkg::nbr_word_t last_q;

  // -----------------------------------------------------------------
  // Line resolution
  // -----------------------------------------------------------------
  // A floating line shows the inverse of its last level, so a stale
  // value can never pass for a driven one.
  always_comb
  begin
    for (int b = 0; b < `NBR_WIDTH; b++)
    begin
      if (oe_i[b])
        bus_o[b] = q_i[b];
      else if (talk_i)
        bus_o[b] = talk_word_i[b];
      else
        bus_o[b] = ~last_q[b];
    end
  end

  // Two drivers on one line is a bus fight.
  assign clash_o = talk_i & (|oe_i);

  // Remember the last level of each line.
  always_ff @(posedge clk_sys_i)
  begin
    last_q <= bus_o;
  end
endmodule : nbr_bus_partner

// *** sim/testbench.sv ***
// Purpose: Self-checking bench of the nine-bit bus register.
// Assumes: Both build variants see one shared stimulus.
// Notes:   Inputs change on the falling clock edge or 1 ns after it.
`timescale 1ns/1ns
`include "nbr_params.svh"

module testbench;
  logic clk_sys_i;
  logic rst_n_i;
  logic valid, gate_n, zero_n, drv_n, talk, clash;
  logic rdy0, rdy1, pend0, pend1;
  logic [$clog2(`NBR_DEPTH):0] lvl0, lvl1;
  nbr_pkg::nbr_word_t data, q0, q1, oe0, oe1, bus, talk_word;
  int n_mismatch, n_compared, cycles;

  // ---------------------------------------------------------------
  // Both build variants, and the shared bus
  // ---------------------------------------------------------------
  nbr_bus_register #(.INVERT(1'b0)) dut (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .data_i(data),
    .data_valid_i(valid), .data_ready_o(rdy0),
    .capture_gate_n_i(gate_n), .async_zero_n_i(zero_n),
    .output_drive_enable_n_i(drv_n), .q_o(q0), .q_oe_o(oe0),
    .fifo_level_o(lvl0), .word_pending_o(pend0));
  nbr_bus_register #(.INVERT(1'b1)) dut_inv (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .data_i(data),
    .data_valid_i(valid), .data_ready_o(rdy1),
    .capture_gate_n_i(gate_n), .async_zero_n_i(zero_n),
    .output_drive_enable_n_i(drv_n), .q_o(q1), .q_oe_o(oe1),
    .fifo_level_o(lvl1), .word_pending_o(pend1));
  nbr_bus_partner bus_model (
    .clk_sys_i(clk_sys_i), .q_i(q0), .oe_i(oe0), .talk_i(talk),
    .talk_word_i(talk_word), .bus_o(bus), .clash_o(clash));

  // Clock of 8 ns.
  initial
  begin
    clk_sys_i = 1'b0;
    forever #4 clk_sys_i = ~clk_sys_i;
  end

  // A hang ends the run as a failure well past the normal length.
  always @(posedge clk_sys_i)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      n_mismatch++;
      conclude();
    end
  end

  // ---------------------------------------------------------------
  // Compare and closing tasks
  // ---------------------------------------------------------------
  task automatic chk_word(string name, nbr_pkg::nbr_word_t e,
                          nbr_pkg::nbr_word_t g);
    n_compared++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", name, e, g);
    end
  endtask : chk_word

  task automatic chk_flag(string name, logic e, logic g);
    n_compared++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("BAD %s expected %b seen %b", name, e, g);
    end
  endtask : chk_flag

  // The inverting variant must hold the complement of the same word.
  task automatic chk_q(string name, nbr_pkg::nbr_word_t w);
    chk_word(name, w, q0);
    chk_word({name, "_inv"}, ~w, q1);
  endtask : chk_q

  task automatic conclude();
    if (n_mismatch == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : conclude

  // Offers a word and returns at the falling edge after it was taken;
  // valid stays up so a following word can go back to back.
  task automatic send(nbr_pkg::nbr_word_t w);
    data = w;
    valid = 1'b1;
    for (int i = 0; i < 40 && rdy0 !== 1'b1; i++)
      @(negedge clk_sys_i);
    @(negedge clk_sys_i);
  endtask : send

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_powerup();
    chk_word("oe_powerup", `NBR_OE_OFF, oe0);
    chk_word("oe_inv_powerup", `NBR_OE_OFF, oe1);
    // Reset zeroes the storage in both variants alike.
    chk_word("q_reset", 9'h000, q0);
    chk_word("q_inv_reset", 9'h000, q1);
    drv_n = 1'b0;
    #1 chk_word("oe_armed", `NBR_OE_ON, oe0);
  endtask : t_powerup

  task automatic t_capture();
    @(negedge clk_sys_i);
    gate_n = 1'b0;
    send(9'h1a5);
    send(9'h05a);
    chk_q("q_first", 9'h1a5);
    valid = 1'b0;
    @(negedge clk_sys_i);
    chk_q("q_second", 9'h05a);
    chk_word("bus_driven", 9'h05a, bus);
  endtask : t_capture

  task automatic t_hold();
    gate_n = 1'b1;
    send(9'h0c3);
    valid = 1'b0;
    repeat (3) @(negedge clk_sys_i);
    chk_q("q_hold", 9'h05a);
    chk_flag("pending", 1'b1, pend0);
    gate_n = 1'b0;
    @(negedge clk_sys_i);
    chk_q("q_open", 9'h0c3);
  endtask : t_hold

  task automatic t_clear();
    zero_n = 1'b0;
    #1 chk_word("q_clear", 9'h000, q0);
    chk_word("q_inv_clear", 9'h000, q1);
    send(9'h13c);
    valid = 1'b0;
    repeat (2) @(negedge clk_sys_i);
    chk_word("q_held_clear", 9'h000, q0);
    chk_word("q_inv_held_clear", 9'h000, q1);
    chk_flag("pending_clear", 1'b1, pend0);
    zero_n = 1'b1;
    @(negedge clk_sys_i);
    chk_q("q_after_clear", 9'h13c);
  endtask : t_clear

  task automatic t_release();
    drv_n = 1'b1;
    talk = 1'b1;
    talk_word = 9'h0f0;
    #1 chk_word("oe_released", `NBR_OE_OFF, oe0);
    chk_word("bus_other", 9'h0f0, bus);
    chk_flag("clash", 1'b0, clash);
    send(9'h0ff);
    valid = 1'b0;
    // Three released edges in all before the pins are driven again.
    repeat (2) @(negedge clk_sys_i);
    talk = 1'b0;
    drv_n = 1'b0;
    #1 chk_word("bus_redrive", 9'h0ff, bus);
    chk_q("q_redrive", 9'h0ff);
  endtask : t_release

  // Gate closed: the buffer fills until it refuses, then drains.
  task automatic t_fill();
    @(negedge clk_sys_i);
    gate_n = 1'b1;
    for (int i = 0; i < `NBR_DEPTH; i++)
      send(nbr_pkg::nbr_word_t'(i * 33));
    data = 9'h1ff;
    repeat (2) @(negedge clk_sys_i);
    chk_flag("ready_full", 1'b0, rdy0);
    chk_word("level_full", nbr_pkg::nbr_word_t'(`NBR_DEPTH),
             nbr_pkg::nbr_word_t'(lvl0));
    chk_q("q_stalled", 9'h0ff);
    valid = 1'b0;
    gate_n = 1'b0;
    for (int i = 0; i < `NBR_DEPTH; i++)
    begin
      @(negedge clk_sys_i);
      chk_q("q_drain", nbr_pkg::nbr_word_t'(i * 33));
    end
    @(negedge clk_sys_i);
    chk_flag("pending_empty", 1'b0, pend0);
    chk_flag("ready_empty", 1'b1, rdy0);
  endtask : t_fill

  // Reset for five cycles, then every scenario in turn.
  initial
  begin
    rst_n_i = 1'b0;
    {valid, talk} = 2'b00;
    {gate_n, zero_n, drv_n} = 3'b111;
    data = 9'h000;
    talk_word = 9'h000;
    repeat (5) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    rst_n_i = 1'b1;
    @(negedge clk_sys_i);
    t_powerup();
    t_capture();
    t_hold();
    t_clear();
    t_release();
    t_fill();
    conclude();
  end
endmodule : testbench
